/* common/tac_ch_if.sv */
/*
  signals between the top level and one timer channel.
  assumes: top and channel share one clock and reset.
*/
interface tac_ch_if;
  logic              tick;
  logic              wr_cnt;
  tac_pkg::tac_nib_t wr_gr;
  logic              wr_lvl;
  tac_pkg::tac_word_t wdata;
  tac_pkg::tac_nib_t lvl;
  tac_pkg::tac_nib_t cap;
  tac_pkg::tac_nib_t cap_mode;
  logic              clr_on_a;
  tac_pkg::tac_word_t cnt;
  tac_pkg::tac_grs_t gr;
  tac_pkg::tac_nib_t evt;
  logic              ovf;
  tac_pkg::tac_nib_t pin;

  modport top (
    output tick, wr_cnt, wr_gr, wr_lvl, wdata, lvl, cap, cap_mode, clr_on_a,
    input  cnt, gr, evt, ovf, pin
  );
  modport ch (
    input  tick, wr_cnt, wr_gr, wr_lvl, wdata, lvl, cap, cap_mode, clr_on_a,
    output cnt, gr, evt, ovf, pin
  );
endinterface : tac_ch_if

/* common/tac_params.svh */
/*
  constants for the timer access contention block: register byte offsets,
  field positions, reset values and timing counts.
  assumes: included by bare name, 25 MHz core clock.
*/
`ifndef TAC_PARAMS_SVH
`define TAC_PARAMS_SVH

// register byte offsets
`define TAC_OFS_START     8'h00
`define TAC_OFS_FUNC      8'h04
`define TAC_OFS_LEVEL     8'h08
`define TAC_OFS_IOMODE    8'h0C
`define TAC_OFS_STAT0     8'h10
`define TAC_OFS_STAT1     8'h14
// channel windows: ch0 at 0x20, ch1 at 0x40, counter then four GRs
`define TAC_CH_WIN0       3'h1
`define TAC_CH_WIN1       3'h2
`define TAC_SUB_CNT       3'h0
`define TAC_SUB_GR_LO     3'h1
`define TAC_SUB_GR_HI     3'h4

// field positions and widths
`define TAC_OVF_BIT       4
`define TAC_STAT_W        5
`define TAC_CLR_A_BIT0    8
`define TAC_CLR_A_BIT1    9

// combination mode codes
`define TAC_MODE_NORMAL   2'h0
`define TAC_MODE_RSPWM    2'h2
`define TAC_MODE_CPWM     2'h3

// reset values and counter maximum
`define TAC_RST_LEVEL     8'h00
`define TAC_RST_WORD      16'h0000
`define TAC_CNT_MAX       16'hFFFF

// counter clock: one count per this many core cycles
`define TAC_PRESC_DIV     4
`define TAC_PRESC_LAST    3'h3

`endif

/* common/tac_pkg.sv */
/*
  types shared by the timer access contention block.
  assumes: nothing beyond a SystemVerilog compiler.
*/
package tac_pkg;
  typedef logic [15:0]        tac_word_t;
  typedef logic [3:0]         tac_nib_t;
  typedef logic [3:0][15:0]   tac_grs_t;
endpackage : tac_pkg

/* core/tac_channel.sv */
/*
  one 16-bit timer channel: counter, four general match/capture registers,
  four output pins, and the contention priorities between cpu writes and
  counter events.
  assumes: writes arrive as one-cycle strobes on the access edge.
*/
`include "tac_params.svh"

module tac_channel (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  tac_ch_if.ch      bus
);

  logic             clr;
  tac_pkg::tac_nib_t match;

  ////////////////////////////////////////////////////////////////////////
  // events
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      match[i] = !bus.cap_mode[i] && bus.tick && (bus.cnt == bus.gr[i])
                 && !bus.wr_gr[i];
    end
  end

  assign bus.evt = match | (bus.cap & bus.cap_mode);
  assign clr     = bus.clr_on_a && bus.evt[0];
  // overflow flag still set when a cpu write takes the edge
  assign bus.ovf = bus.tick && (bus.cnt == `TAC_CNT_MAX) && !clr;

  ////////////////////////////////////////////////////////////////////////
  // counter: clear beats write, write beats increment
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      bus.cnt <= `TAC_RST_WORD;
    end else if (clr) begin
      bus.cnt <= `TAC_RST_WORD;
    end else if (bus.wr_cnt) begin
      bus.cnt <= bus.wdata;
    end else if (bus.tick) begin
      bus.cnt <= bus.cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // general registers: capture takes the pre-clear count, beats writes
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      bus.gr <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (bus.cap_mode[i] && bus.cap[i]) begin
          bus.gr[i] <= bus.cnt;
        end else if (bus.wr_gr[i]) begin
          bus.gr[i] <= bus.wdata;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins: level register write wins over a toggle on the same edge
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      bus.pin <= '0;
    end else if (bus.wr_lvl) begin
      bus.pin <= bus.lvl;
    end else begin
      bus.pin <= bus.pin ^ match;
    end
  end

endmodule : tac_channel

/* core/tac_top.sv */
/*
  two-channel 16-bit timer with cpu access contention handling,
  reached over apb with zero wait states.
  assumes: apb master on I_CORE_CLK, capture inputs asynchronous.
*/
// Notes on behaviour
// - counter clear beats cpu counter write
// - cpu counter write beats increment
// - gr write suppresses coincident compare match
// - write beats overflow increment, flag still set
// - read during capture returns old gr
// - capture clear beats increment
// - capture stores count from before clear
// - capture beats cpu gr write
// - no direct change between pwm modes
// - overflow flag at status bit 4
// - level bits set pins until match
// - match does not update level bits
// - level write beats coincident match toggle
// - flag clears only by zero after read-one
// - match fires on counter update edge
`include "tac_params.svh"

module tac_top (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RSTN,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  input  wire logic [7:0]  I_CAP_IN,
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  output logic [7:0]       O_TIO_PIN
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [1:0]  start_ff;
  logic [1:0]  mode_ff;
  logic [1:0]  nxt_mode;
  logic [7:0]  level_ff;
  logic [9:0]  iomode_ff;
  logic [2:0]  presc_ff;
  logic        presc_wrap;
  logic [7:0]  cap_s1_ff;
  logic [7:0]  cap_s2_ff;
  logic [7:0]  cap_s3_ff;
  logic [7:0]  cap_rise;
  logic [1:0][`TAC_STAT_W-1:0] stat_ff;
  logic [1:0][`TAC_STAT_W-1:0] arm_ff;
  logic [1:0][`TAC_STAT_W-1:0] stat_set;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] rd_val;
  logic        rd_hit;
  logic        setup;
  logic        acc_wr;
  logic        acc_rd;
  logic [2:0]  win;
  logic [2:0]  sub;
  logic        sub_ok;
  logic [1:0]  ch_hit;
  // per-channel copies so the read mux indexes plain arrays, not instances
  tac_pkg::tac_word_t cnt_rd [2];
  tac_pkg::tac_grs_t  gr_rd [2];

  tac_ch_if chif [2] ();

  assign O_PRDATA  = prdata_ff;
  assign O_PREADY  = pready_ff;
  assign O_PSLVERR = pslverr_ff;

  ////////////////////////////////////////////////////////////////////////
  // apb phases: setup edge samples read data, access edge commits
  assign setup  = I_PSEL && !I_PENABLE;
  assign acc_wr = I_PSEL && I_PENABLE && pready_ff && I_PWRITE;
  assign acc_rd = I_PSEL && I_PENABLE && pready_ff && !I_PWRITE;
  assign win    = I_PADDR[7:5];
  assign sub    = I_PADDR[4:2];
  assign sub_ok = (I_PADDR[1:0] == 2'h0) && (sub <= `TAC_SUB_GR_HI);
  assign ch_hit[0] = sub_ok && (win == `TAC_CH_WIN0);
  assign ch_hit[1] = sub_ok && (win == `TAC_CH_WIN1);

  ////////////////////////////////////////////////////////////////////////
  // capture input synchronisers and rising edge detect
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      cap_s1_ff <= '0;
      cap_s2_ff <= '0;
      cap_s3_ff <= '0;
    end else begin
      cap_s1_ff <= I_CAP_IN;
      cap_s2_ff <= cap_s1_ff;
      cap_s3_ff <= cap_s2_ff;
    end
  end

  assign cap_rise = cap_s2_ff & ~cap_s3_ff;

  ////////////////////////////////////////////////////////////////////////
  // counter clock prescaler
  assign presc_wrap = (presc_ff == `TAC_PRESC_LAST);

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      presc_ff <= '0;
    end else if (presc_wrap) begin
      presc_ff <= '0;
    end else begin
      presc_ff <= presc_ff + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // channels
  generate
    for (genvar c = 0; c < 2; c++) begin : g_ch
      assign chif[c].tick     = start_ff[c] && presc_wrap;
      assign chif[c].wr_cnt   = acc_wr && ch_hit[c] && (sub == `TAC_SUB_CNT);
      assign chif[c].wdata    = I_PWDATA[15:0];
      assign chif[c].wr_lvl   = acc_wr && (I_PADDR == `TAC_OFS_LEVEL);
      assign chif[c].lvl      = I_PWDATA[4*c +: 4];
      assign chif[c].cap      = cap_rise[4*c +: 4];
      assign chif[c].cap_mode = iomode_ff[4*c +: 4];
      assign chif[c].clr_on_a = iomode_ff[`TAC_CLR_A_BIT0 + c];
      for (genvar g = 0; g < 4; g++) begin : g_gr
        assign chif[c].wr_gr[g] = acc_wr && ch_hit[c]
                                  && (sub == 3'(g + 1));
      end
      assign O_TIO_PIN[4*c +: 4] = chif[c].pin;
      assign stat_set[c] = {chif[c].ovf, chif[c].evt};
      assign cnt_rd[c]   = chif[c].cnt;
      assign gr_rd[c]    = chif[c].gr;

      tac_channel u_ch (
        .i_clk  (I_CORE_CLK),
        .i_rstn (I_RSTN),
        .bus    (chif[c].ch)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // start bits
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      start_ff <= '0;
    end else if (acc_wr && (I_PADDR == `TAC_OFS_START)) begin
      start_ff <= I_PWDATA[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // combination mode: a direct pwm-to-pwm change is refused
  always_comb begin
    nxt_mode = I_PWDATA[1:0];
    if ((mode_ff != `TAC_MODE_NORMAL) && (nxt_mode != `TAC_MODE_NORMAL)
        && (nxt_mode != mode_ff)) begin
      nxt_mode = mode_ff;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      mode_ff <= `TAC_MODE_NORMAL;
    end else if (acc_wr && (I_PADDR == `TAC_OFS_FUNC)) begin
      mode_ff <= nxt_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output level register: holds what software wrote, never the pins
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      level_ff <= `TAC_RST_LEVEL;
    end else if (acc_wr && (I_PADDR == `TAC_OFS_LEVEL)) begin
      level_ff <= I_PWDATA[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture/compare select and clear-on-a
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      iomode_ff <= '0;
    end else if (acc_wr && (I_PADDR == `TAC_OFS_IOMODE)) begin
      iomode_ff <= I_PWDATA[9:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags: set wins; a zero clears only a bit seen as one
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      stat_ff <= '0;
      arm_ff  <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (acc_wr && (I_PADDR == (c == 0 ? `TAC_OFS_STAT0 : `TAC_OFS_STAT1)))
        begin
          stat_ff[c] <= (stat_ff[c] & ~(arm_ff[c] & ~I_PWDATA[4:0]))
                        | stat_set[c];
          arm_ff[c]  <= '0;
        end else begin
          stat_ff[c] <= stat_ff[c] | stat_set[c];
          if (acc_rd && (I_PADDR == (c == 0 ? `TAC_OFS_STAT0 : `TAC_OFS_STAT1)))
          begin
            arm_ff[c] <= prdata_ff[4:0];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    if (ch_hit[0] || ch_hit[1]) begin
      for (int c = 0; c < 2; c++) begin
        if (ch_hit[c]) begin
          if (sub == `TAC_SUB_CNT) begin
            rd_val[15:0] = cnt_rd[c];
          end else begin
            rd_val[15:0] = gr_rd[c][sub[1:0] - 2'h1];
          end
        end
      end
    end else begin
      unique case (I_PADDR)
        `TAC_OFS_START:  rd_val[1:0] = start_ff;
        `TAC_OFS_FUNC:   rd_val[1:0] = mode_ff;
        `TAC_OFS_LEVEL:  rd_val[7:0] = level_ff;
        `TAC_OFS_IOMODE: rd_val[9:0] = iomode_ff;
        `TAC_OFS_STAT0:  rd_val[4:0] = stat_ff[0];
        `TAC_OFS_STAT1:  rd_val[4:0] = stat_ff[1];
        default:         rd_hit = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb answer: data taken at setup, before any capture on that edge
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      prdata_ff  <= '0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup && !rd_hit;
      if (setup && !I_PWRITE) begin
        prdata_ff <= rd_val;
      end
    end
  end

endmodule : tac_top

/* verification/tac_cpu.sv */
/*
  cpu model: apb master for tac_top, one transfer per xfer call.
  assumes: slave answers with pready; the bench bounds every wait.
*/
module tac_cpu (
  input  wire logic        i_clk,
  input  wire logic        i_ready,
  input  wire logic [31:0] i_rdata,
  output logic             o_sel,
  output logic             o_en,
  output logic             o_wr,
  output logic [7:0]       o_addr,
  output logic [31:0]      o_wdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_sel = 1'b0;
    o_en = 1'b0;
    o_wr = 1'b0;
    o_addr = 8'h00;
    o_wdata = 32'h0000_0000;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge i_clk);
    o_sel <= 1'b1;
    o_en <= 1'b0;
    o_wr <= w;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_en <= 1'b1;
    do @(posedge i_clk); while (i_ready !== 1'b1);
    r = i_rdata;
    o_sel <= 1'b0;
    o_en <= 1'b0;
    // released lines do not keep the old value
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask : xfer
endmodule : tac_cpu

/* verification/tac_monitor.sv */
/*
  checker on tac_top ports: apb handshake, level register, status width.
  assumes: one clock, synchronous active-low reset.
*/
`include "tac_params.svh"

module tac_monitor (
  input wire logic        I_CORE_CLK,
  input wire logic        I_RSTN,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [7:0]  I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [7:0]  I_CAP_IN,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic [7:0]  O_TIO_PIN
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] lvl_ff;
  wire logic  lvl_wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE
                       && I_PADDR == `TAC_OFS_LEVEL;

  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RSTN);

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      lvl_ff <= 8'h00;
    end else if (lvl_wr) begin
      lvl_ff <= I_PWDATA[7:0];
    end
  end

  ////////////////////////////////////////
  sequence s_setup;
    I_PSEL && !I_PENABLE;
  endsequence
  sequence s_rd(a);
    s_setup ##0 (!I_PWRITE && I_PADDR == a);
  endsequence

  chk_ready_setup: assert property (s_setup |=> O_PREADY)
    else $error("no pready after setup");
  chk_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
    else $error("pready longer than one cycle");
  chk_ready_cause: assert property ($rose(O_PREADY) |-> $past(I_PSEL) && !$past(I_PENABLE))
    else $error("pready without setup");
  chk_err_unmapped: assert property (s_setup ##0 I_PADDR == 8'hFC |=> O_PSLVERR && O_PREADY)
    else $error("no pslverr on unmapped address");
  chk_err_mapped: assert property (s_rd(`TAC_OFS_LEVEL) |=> !O_PSLVERR)
    else $error("pslverr on mapped address");
  chk_rdata_hold: assert property (!(I_PSEL && !I_PENABLE && !I_PWRITE) |=> $stable(O_PRDATA))
    else $error("read data moved without read");
  chk_level_read: assert property (
    s_rd(`TAC_OFS_LEVEL) |=> O_PRDATA == {24'h00_0000, lvl_ff})
    else $error("level register read back wrong");
  chk_level_pins: assert property (lvl_wr |=> O_TIO_PIN == lvl_ff)
    else $error("pins differ from written level");
  chk_status_width: assert property (
    s_rd(`TAC_OFS_STAT0) |=> O_PRDATA[31:5] == 27'h000_0000)
    else $error("status bits above overflow flag");
endmodule : tac_monitor

bind tac_top tac_monitor u_mon (
  .I_CORE_CLK(I_CORE_CLK), .I_RSTN(I_RSTN), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .I_CAP_IN(I_CAP_IN), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_TIO_PIN(O_TIO_PIN)
);

/* verification/timer_access_contention_test.sv */
/*
  bench for tac_top: level register, compare match, flags, capture, modes.
  assumes: tac_cpu drives apb; 25 MHz clock.
*/
`include "tac_params.svh"

module timer_access_contention_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        sel, en, wr, rdy, err;
  logic [7:0]  addr, pins;
  logic [7:0]  cap = 8'h00;
  logic [31:0] wdata, rdata, v, lv;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h0000_f5a5;
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc = 0;

  always #20 clk = ~clk;

  tac_top dut (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_PSEL(sel), .I_PENABLE(en),
    .I_PWRITE(wr), .I_PADDR(addr), .I_PWDATA(wdata), .I_CAP_IN(cap),
    .O_PRDATA(rdata), .O_PREADY(rdy), .O_PSLVERR(err), .O_TIO_PIN(pins));
  tac_cpu cpu (.i_clk(clk), .i_ready(rdy), .i_rdata(rdata), .o_sel(sel),
    .o_en(en), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));

  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    cpu.xfer(1'b1, a, d, r);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    exp_q.push_back(e);
    cpu.xfer(1'b0, a, 32'h0000_0000, r);
  endtask : rd_reg

  task automatic end_sim();
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // oldest expectation meets each completed read
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (sel && en && rdy === 1'b1 && !wr && exp_q.size() > 0) begin
      chk(rdata, exp_q.pop_front());
    end
    if (cyc == 1500) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(`TAC_OFS_LEVEL, 32'h0000_0000);
    rd_reg(8'hFC, 32'h0000_0000);
    repeat (3) begin
      lv = rnd() & 32'h0000_00FF;
      wr_reg(`TAC_OFS_LEVEL, lv);
      rd_reg(`TAC_OFS_LEVEL, lv);
      chk({24'h00_0000, pins}, lv);
    end
    for (int i = 1; i < 4; i++) begin
      wr_reg(8'h24 + 8'(4 * i), 32'h0000_8000);
    end
    wr_reg(8'h24, 32'h0000_0003);
    wr_reg(`TAC_OFS_START, 32'h0000_0001);
    repeat (24) @(posedge clk);
    wr_reg(`TAC_OFS_START, 32'h0000_0000);
    chk({24'h00_0000, pins}, lv ^ 32'h0000_0001);
    rd_reg(`TAC_OFS_LEVEL, lv);
    // counter stopped: copy the pins into the level bits before restarting
    lv = lv ^ 32'h0000_0001;
    wr_reg(`TAC_OFS_LEVEL, {24'h00_0000, pins});
    rd_reg(`TAC_OFS_LEVEL, lv);
    rd_reg(`TAC_OFS_STAT0, 32'h0000_0001);
    wr_reg(8'h24, 32'h0000_8000);
    wr_reg(8'h20, 32'h0000_FFFF);
    wr_reg(`TAC_OFS_START, 32'h0000_0001);
    repeat (8) @(posedge clk);
    wr_reg(`TAC_OFS_START, 32'h0000_0000);
    wr_reg(`TAC_OFS_STAT0, 32'h0000_00EF);
    rd_reg(`TAC_OFS_STAT0, 32'h0000_0011);
    wr_reg(`TAC_OFS_STAT0, 32'h0000_00EF);
    rd_reg(`TAC_OFS_STAT0, 32'h0000_0001);
    v = rnd() & 32'h0000_FFFF;
    wr_reg(`TAC_OFS_IOMODE, 32'h0000_0101);
    wr_reg(8'h20, v);
    cap <= 8'h01;
    repeat (4) @(posedge clk);
    cap <= 8'h00;
    repeat (6) @(posedge clk);
    rd_reg(8'h24, v);
    rd_reg(8'h20, 32'h0000_0000);
    wr_reg(`TAC_OFS_FUNC, 32'h0000_0002);
    wr_reg(`TAC_OFS_FUNC, 32'h0000_0003);
    rd_reg(`TAC_OFS_FUNC, 32'h0000_0002);
    wr_reg(`TAC_OFS_FUNC, 32'h0000_0000);
    wr_reg(`TAC_OFS_FUNC, 32'h0000_0003);
    rd_reg(`TAC_OFS_FUNC, 32'h0000_0003);
    repeat (2) @(posedge clk);
    // every noted read must have met its answer
    if (exp_q.size() != 0) begin
      err_total++;
      $display("ERROR %0t reads left without an answer", $time);
    end
    end_sim();
  end
endmodule : timer_access_contention_test
